// ===== hdl/cmpn_node.sv
// top of the cell monitor pump node: conversions, balancing drives, chain relay
// What this block does
// R1 - drives switch at commanded frequency and duty
// R2 - south duty is 100 minus north duty
// R3 - north high phase is the on-time
// R4 - conversion ends within 80 ms
// R5 - conversions start only on controller command
// R6 - latest result per cell kept and readable
// R7 - temperature uses same converters, independent
// R8 - internal plus two external temperature sources
// R9 - cell 1 south pumps downward, unused lowest
// R10 - cell 1 north pumps into cell 2
// R11 - cell 2 south pumps into cell 1
// R12 - cell 2 north pumps upward, unused highest
// R13 - drives only follow controller balancing commands
// R14 - every serial bit buffered and regenerated
// R15 - input from lower node, output upward
// R16 - active on traffic, standby when idle
// R17 - all drives off after reset
`timescale 1ns/1ns
module cmpn_node #(
  parameter int unsigned CONV_MAX_CYC    = cmpn_pkg::CONV_MAX_CYC,
  parameter bit          IS_LOWEST_NODE  = 1'b0,
  parameter bit          IS_HIGHEST_NODE = 1'b0
) (
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       chain_serial_in_i,
  output logic                            chain_serial_out_o,
  input  wire cmpn_pkg::cmpn_cmd_s        cmd_i,
  input  wire cmpn_pkg::cmpn_adc_s        adc_i,
  output cmpn_pkg::cmpn_adc_ctl_s         adc_ctl_o,
  input  wire cmpn_pkg::cmpn_rd_s         rd_i,
  output logic                            rd_ack_o,
  output logic [cmpn_pkg::RES_W-1:0]      rd_data_o,
  output logic                            conv_busy_o,
  output logic                            conv_timeout_o,
  output logic                            active_o,
  output logic                            cell1_north_drive_o,
  output logic                            cell1_south_drive_o,
  output logic                            cell2_north_drive_o,
  output logic                            cell2_south_drive_o
);

  typedef struct packed {
    cmpn_pkg::cmpn_conv_e                                   conv;
    logic [cmpn_pkg::TMR_W-1:0]                             timer;
    logic [1:0]                                             done_seen;
    logic [cmpn_pkg::NUM_CELLS-1:0][cmpn_pkg::RES_W-1:0]    cell_res;
    logic [cmpn_pkg::NUM_TEMPS-1:0][cmpn_pkg::RES_W-1:0]    temp_res;
    logic [1:0]                                             temp_sel;
    logic [3:0]                                             drive_en;
    logic [cmpn_pkg::PER_W-1:0]                             period;
    logic [cmpn_pkg::PER_W-1:0]                             north_on;
    logic                                                   ser_out;
    logic                                                   active;
    logic                                                   timeout;
    logic                                                   busy;
    cmpn_pkg::cmpn_adc_ctl_s                                adc_ctl;
    logic                                                   rd_ack;
    logic [cmpn_pkg::RES_W-1:0]                             rd_data;
  } cmpn_node_s;

  cmpn_node_s st_ff;
  cmpn_node_s nxt_st;
  logic       chain_edge;
  logic       conv_cmd;

  // ==========================================================================
  // result lookup
  function automatic logic [cmpn_pkg::RES_W-1:0] pick_result(input cmpn_node_s s, input logic [2:0] sel);
    case (sel)
      cmpn_pkg::RSEL_CELL1: pick_result = s.cell_res[0];
      cmpn_pkg::RSEL_CELL2: pick_result = s.cell_res[1];
      cmpn_pkg::RSEL_TINT:  pick_result = s.temp_res[cmpn_pkg::TSEL_INT];
      cmpn_pkg::RSEL_TEXT1: pick_result = s.temp_res[cmpn_pkg::TSEL_EXT1];
      cmpn_pkg::RSEL_TEXT2: pick_result = s.temp_res[cmpn_pkg::TSEL_EXT2];
      default:              pick_result = cmpn_pkg::RES_RST;
    endcase
  endfunction

  assign chain_edge = chain_serial_in_i ^ st_ff.ser_out;
  assign conv_cmd   = cmd_i.valid && (cmd_i.op == cmpn_pkg::OP_VOLT || cmd_i.op == cmpn_pkg::OP_TEMP);

  // ==========================================================================
  // next state
  always_comb begin
    nxt_st               = st_ff;
    nxt_st.ser_out       = chain_serial_in_i; // R14 R15
    nxt_st.adc_ctl.start = 2'b00;
    nxt_st.rd_ack        = rd_i.valid; // R6
    if (rd_i.valid) begin
      nxt_st.rd_data = pick_result(st_ff, rd_i.sel); // R6
    end
    // balancing command: drives follow it and nothing else
    if (cmd_i.valid && cmd_i.op == cmpn_pkg::OP_PUMP) begin
      nxt_st.drive_en = cmd_i.drive_en; // R13
      nxt_st.period   = cmd_i.period; // R1
      nxt_st.north_on = cmd_i.north_on; // R1
      if (IS_LOWEST_NODE) begin
        nxt_st.drive_en[cmpn_pkg::DRV_C1S] = 1'b0; // R9
      end
      if (IS_HIGHEST_NODE) begin
        nxt_st.drive_en[cmpn_pkg::DRV_C2N] = 1'b0; // R12
      end
    end
    case (st_ff.conv)
      cmpn_pkg::CMPN_IDLE: begin
        if (conv_cmd) begin // R5
          nxt_st.timer     = '0;
          nxt_st.done_seen = 2'b00;
          nxt_st.timeout   = 1'b0;
          if (cmd_i.op == cmpn_pkg::OP_VOLT) begin
            nxt_st.conv              = cmpn_pkg::CMPN_VOLT;
            nxt_st.adc_ctl.start     = 2'b11; // R5
            nxt_st.adc_ctl.temp_mode = 1'b0;
          end else begin
            nxt_st.conv              = cmpn_pkg::CMPN_TEMP;
            nxt_st.adc_ctl.start     = 2'b01; // R7
            nxt_st.adc_ctl.temp_mode = 1'b1;
            nxt_st.adc_ctl.temp_sel  = cmd_i.temp_sel; // R8
            nxt_st.temp_sel          = cmd_i.temp_sel;
          end
        end
      end
      cmpn_pkg::CMPN_VOLT: begin
        nxt_st.timer = st_ff.timer + cmpn_pkg::TMR_W'(1);
        for (int i = 0; i < cmpn_pkg::NUM_CELLS; i++) begin
          if (adc_i.done[i] && !st_ff.done_seen[i]) begin
            nxt_st.cell_res[i]  = adc_i.data[i]; // R6
            nxt_st.done_seen[i] = 1'b1;
          end
        end
        if (&nxt_st.done_seen) begin
          nxt_st.conv = cmpn_pkg::CMPN_IDLE;
        end else if (st_ff.timer >= cmpn_pkg::TMR_W'(CONV_MAX_CYC - 1)) begin
          nxt_st.conv    = cmpn_pkg::CMPN_IDLE; // R4
          nxt_st.timeout = 1'b1;
        end
      end
      cmpn_pkg::CMPN_TEMP: begin
        nxt_st.timer = st_ff.timer + cmpn_pkg::TMR_W'(1);
        if (adc_i.done[0]) begin
          if (st_ff.temp_sel <= cmpn_pkg::TSEL_EXT2) begin
            nxt_st.temp_res[st_ff.temp_sel] = adc_i.data[0]; // R7 R8
          end
          nxt_st.conv = cmpn_pkg::CMPN_IDLE;
        end else if (st_ff.timer >= cmpn_pkg::TMR_W'(CONV_MAX_CYC - 1)) begin
          nxt_st.conv    = cmpn_pkg::CMPN_IDLE; // R4
          nxt_st.timeout = 1'b1;
        end
      end
      default: begin
        nxt_st.conv = cmpn_pkg::CMPN_IDLE;
      end
    endcase
    // active while traffic, conversion or pumping lasts
    nxt_st.active = chain_edge || cmd_i.valid || (nxt_st.conv != cmpn_pkg::CMPN_IDLE)
                    || (|nxt_st.drive_en); // R16
    nxt_st.busy   = (nxt_st.conv != cmpn_pkg::CMPN_IDLE);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff          <= '0;
      st_ff.conv     <= cmpn_pkg::CMPN_IDLE;
      st_ff.drive_en <= cmpn_pkg::DRIVE_RST; // R17
      st_ff.period   <= cmpn_pkg::PERIOD_RST;
      st_ff.north_on <= cmpn_pkg::NORTH_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // balancing drive pairs, one per cell
  logic [cmpn_pkg::NUM_CELLS-1:0] north_drv;
  logic [cmpn_pkg::NUM_CELLS-1:0] south_drv;

  generate
    for (genvar c = 0; c < cmpn_pkg::NUM_CELLS; c++) begin : g_cell
      cmpn_pump_pwm #(
        .PER_W(cmpn_pkg::PER_W)
      ) u_pwm (
        .clk_i        (clk_i),
        .arst_n_i     (arst_n_i),
        .north_en_i   (st_ff.drive_en[2*c]),
        .south_en_i   (st_ff.drive_en[2*c+1]),
        .period_i     (st_ff.period),
        .north_on_i   (st_ff.north_on),
        .north_drive_o(north_drv[c]),
        .south_drive_o(south_drv[c])
      );
    end
  endgenerate

  // ==========================================================================
  // outputs
  assign cell1_north_drive_o = north_drv[0]; // R10
  assign cell1_south_drive_o = south_drv[0]; // R9
  assign cell2_north_drive_o = north_drv[1]; // R12
  assign cell2_south_drive_o = south_drv[1]; // R11
  assign chain_serial_out_o  = st_ff.ser_out;
  assign adc_ctl_o           = st_ff.adc_ctl;
  assign rd_ack_o            = st_ff.rd_ack;
  assign rd_data_o           = st_ff.rd_data;
  assign conv_busy_o         = st_ff.busy;
  assign conv_timeout_o      = st_ff.timeout;
  assign active_o            = st_ff.active;

  // ==========================================================================
  // checks
  a_relay_regen: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R14
    ##1 (chain_serial_out_o == $past(chain_serial_in_i))) else $error("serial bit not relayed");

  a_conv_bounded: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R4
    conv_busy_o |-> (st_ff.timer < cmpn_pkg::TMR_W'(CONV_MAX_CYC))) else $error("conversion overran bound");

  a_start_on_cmd: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
    (|adc_ctl_o.start) |-> $past(conv_cmd && !conv_busy_o)) else $error("conversion started without command");

  a_volt_both_adc: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
    (conv_cmd && cmd_i.op == cmpn_pkg::OP_VOLT && !conv_busy_o) |=> (adc_ctl_o.start == 2'b11))
    else $error("voltage command did not start both converters");

  a_temp_one_adc: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R7
    (conv_cmd && cmd_i.op == cmpn_pkg::OP_TEMP && !conv_busy_o) |=> (adc_ctl_o.start == 2'b01 && adc_ctl_o.temp_mode))
    else $error("temperature command start wrong");

  a_result_kept: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R6
    (st_ff.conv != cmpn_pkg::CMPN_VOLT) |=> $stable(st_ff.cell_res)) else $error("cell result changed while idle");

  a_read_answer: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R6
    (rd_i.valid && rd_i.sel == cmpn_pkg::RSEL_CELL2) |=> (rd_ack_o && rd_data_o == $past(st_ff.cell_res[1])))
    else $error("read answer wrong");

  a_drives_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R13 R17
    (st_ff.drive_en == 4'h0) |=> !(cell1_north_drive_o || cell1_south_drive_o || cell2_north_drive_o
    || cell2_south_drive_o)) else $error("drive on without enable");

  a_standby_return: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R16
    (!chain_edge && !cmd_i.valid && !conv_busy_o && st_ff.drive_en == 4'h0) |=> !active_o)
    else $error("did not return to standby");

  a_wake_on_traffic: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R16
    chain_edge |=> active_o) else $error("traffic did not wake node");

endmodule

// ===== hdl/cmpn_pkg.sv
// shared constants and types of the cell monitor pump node
package cmpn_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned PUMP_FREQ_HZ    = 204_800;
  localparam int unsigned PUMP_PERIOD_CYC = CLK_HZ / PUMP_FREQ_HZ;
  localparam int unsigned DUTY_FULL_PCT   = 100;
  localparam int unsigned NORTH_DUTY_PCT  = 33;
  localparam int unsigned NORTH_ON_CYC    = PUMP_PERIOD_CYC * NORTH_DUTY_PCT / DUTY_FULL_PCT;
  localparam int unsigned CONV_MAX_MS     = 80;
  localparam int unsigned CONV_MAX_CYC    = CONV_MAX_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // widths and indices
  localparam int unsigned PER_W     = 8;
  localparam int unsigned RES_W     = 16;
  localparam int unsigned NUM_CELLS = 2;
  localparam int unsigned NUM_TEMPS = 3;
  localparam int unsigned TMR_W     = 32;

  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_VOLT = 2'h1;
  localparam logic [1:0] OP_TEMP = 2'h2;
  localparam logic [1:0] OP_PUMP = 2'h3;

  localparam logic [1:0] TSEL_INT  = 2'h0;
  localparam logic [1:0] TSEL_EXT1 = 2'h1;
  localparam logic [1:0] TSEL_EXT2 = 2'h2;

  // read selector: cells 0..1, temperatures 2..4
  localparam logic [2:0] RSEL_CELL1 = 3'h0;
  localparam logic [2:0] RSEL_CELL2 = 3'h1;
  localparam logic [2:0] RSEL_TINT  = 3'h2;
  localparam logic [2:0] RSEL_TEXT1 = 3'h3;
  localparam logic [2:0] RSEL_TEXT2 = 3'h4;

  // drive enable bit positions
  localparam int unsigned DRV_C1N = 0;
  localparam int unsigned DRV_C1S = 1;
  localparam int unsigned DRV_C2N = 2;
  localparam int unsigned DRV_C2S = 3;

  localparam logic [PER_W-1:0] PERIOD_RST = PER_W'(PUMP_PERIOD_CYC);
  localparam logic [PER_W-1:0] NORTH_RST  = PER_W'(NORTH_ON_CYC);
  localparam logic [3:0]       DRIVE_RST  = 4'h0;
  localparam logic [RES_W-1:0] RES_RST    = 16'h0000;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    CMPN_IDLE = 3'b001,
    CMPN_VOLT = 3'b010,
    CMPN_TEMP = 3'b100
  } cmpn_conv_e;

  typedef struct packed {
    logic             valid;
    logic [1:0]       op;
    logic [1:0]       temp_sel;
    logic [3:0]       drive_en;
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] north_on;
  } cmpn_cmd_s;

  typedef struct packed {
    logic [1:0]            done;
    logic [1:0][RES_W-1:0] data;
  } cmpn_adc_s;

  typedef struct packed {
    logic [1:0] start;
    logic       temp_mode;
    logic [1:0] temp_sel;
  } cmpn_adc_ctl_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] sel;
  } cmpn_rd_s;

endpackage

// ===== hdl/cmpn_pump_pwm.sv
// one cell's north/south balancing gate pwm pair
`timescale 1ns/1ns
module cmpn_pump_pwm #(
  parameter int unsigned PER_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             north_en_i,
  input  wire logic             south_en_i,
  input  wire logic [PER_W-1:0] period_i,
  input  wire logic [PER_W-1:0] north_on_i,
  output logic                  north_drive_o,
  output logic                  south_drive_o
);

  typedef struct packed {
    logic [PER_W-1:0] cnt;
    logic             north;
    logic             south;
  } cmpn_pwm_s;

  cmpn_pwm_s st_ff;
  cmpn_pwm_s nxt_st;

  // ==========================================================================
  // period counter and drive compare
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.cnt >= period_i - PER_W'(1)) begin
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + PER_W'(1);
    end
    nxt_st.north = north_en_i && (st_ff.cnt < north_on_i); // R1 R3
    nxt_st.south = south_en_i && (st_ff.cnt >= north_on_i); // R2
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign north_drive_o = st_ff.north;
  assign south_drive_o = st_ff.south;

  // ==========================================================================
  // checks
  a_pair_exclusive: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
    !(north_drive_o && south_drive_o)) else $error("north and south drive both high");

  a_north_high_phase: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R3
    (north_en_i && st_ff.cnt < north_on_i) |=> north_drive_o) else $error("north on-time missing");

  a_south_complement: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
    (south_en_i && st_ff.cnt >= north_on_i) |=> south_drive_o) else $error("south phase missing");

  a_counter_wrap: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R1
    (st_ff.cnt >= period_i - PER_W'(1)) |=> (st_ff.cnt == '0)) else $error("pwm counter did not wrap");

endmodule

// ===== dv/cmpn_adc_model.sv
// converter pair model answering the node's start pulses
`timescale 1ns/1ns
module cmpn_adc_model (
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  wire cmpn_pkg::cmpn_adc_ctl_s ctl_i,
  input  wire logic [31:0]             lag_i,
  input  wire logic [1:0][15:0]        val_i,
  output cmpn_pkg::cmpn_adc_s          adc_o
);
  // ==========================================================================
  // lag 0 means the converters never answer
  int unsigned cnt;
  logic [1:0]  pend;
  logic [15:0] junk;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt   <= 0;
      pend  <= 2'h0;
      junk  <= 16'h5a5a;
      adc_o <= '0;
    end else begin
      junk       <= junk + 16'h0001;
      adc_o.done <= 2'h0;
      adc_o.data <= {~junk, junk};
      if (ctl_i.start != 2'h0) begin
        pend <= ctl_i.start;
        cnt  <= 1;
      end else if (pend != 2'h0 && lag_i != 0) begin
        if (cnt >= lag_i) begin
          adc_o.done <= pend;
          adc_o.data <= val_i;
          pend       <= 2'h0;
        end
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ===== dv/test_cell_monitor_pump_node.sv
// self-checking bench of the cell monitor pump node
`timescale 1ns/1ns
module test_cell_monitor_pump_node;
  // ==========================================================================
  // signals
  logic                    clk_i = 1'b0;
  logic                    arst_n_i = 1'b0;
  logic                    si = 1'b0;
  cmpn_pkg::cmpn_cmd_s     cmd = '0;
  cmpn_pkg::cmpn_rd_s      rd = '0;
  cmpn_pkg::cmpn_adc_s     adc;
  cmpn_pkg::cmpn_adc_ctl_s ctl;
  logic                    so, ack, busy, tmo, act;
  logic [15:0]             rdata;
  logic [3:0]              drv;
  logic [3:0]              drv_e;
  int unsigned             lag = 10;
  logic [1:0][15:0]        val = '0;
  int                      seed = 80338;
  int                      fails = 0;
  int                      check_count = 0;
  logic [15:0]             v0, v1;
  logic                    last;
  logic [7:0]              pe, no;

  always #25 clk_i = ~clk_i;

  cmpn_node #(.CONV_MAX_CYC(50)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .chain_serial_in_i(si), .chain_serial_out_o(so),
    .cmd_i(cmd), .adc_i(adc), .adc_ctl_o(ctl), .rd_i(rd), .rd_ack_o(ack), .rd_data_o(rdata),
    .conv_busy_o(busy), .conv_timeout_o(tmo), .active_o(act),
    .cell1_north_drive_o(drv[0]), .cell1_south_drive_o(drv[1]),
    .cell2_north_drive_o(drv[2]), .cell2_south_drive_o(drv[3]));

  // end-of-string node: lowest cell-1 south and highest cell-2 north forced off
  cmpn_node #(.CONV_MAX_CYC(50), .IS_LOWEST_NODE(1'b1), .IS_HIGHEST_NODE(1'b1)) dut_end (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .chain_serial_in_i(si), .chain_serial_out_o(),
    .cmd_i(cmd), .adc_i(adc), .adc_ctl_o(), .rd_i(rd), .rd_ack_o(), .rd_data_o(),
    .conv_busy_o(), .conv_timeout_o(), .active_o(),
    .cell1_north_drive_o(drv_e[0]), .cell1_south_drive_o(drv_e[1]),
    .cell2_north_drive_o(drv_e[2]), .cell2_south_drive_o(drv_e[3]));

  cmpn_adc_model adc_m (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ctl_i(ctl), .lag_i(lag), .val_i(val), .adc_o(adc));

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic send(input logic [1:0] op, input logic [1:0] ts, input logic [3:0] de,
                      input logic [7:0] p, input logic [7:0] n);
    @(posedge clk_i);
    cmd <= '{valid: 1'b1, op: op, temp_sel: ts, drive_en: de, period: p, north_on: n};
    @(posedge clk_i);
    cmd.valid <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic read(input logic [2:0] s, input logic [15:0] exp);
    @(posedge clk_i);
    rd <= '{valid: 1'b1, sel: s};
    @(posedge clk_i);
    rd.valid <= 1'b0;
    @(negedge clk_i);
    check(ack, 1);
    check(rdata, exp);
  endtask

  task automatic wait_idle(input int lim);
    int i;
    for (i = 0; i < lim && busy !== 1'b0; i++) @(negedge clk_i);
    check(busy, 0);
  endtask

  function automatic int exp_hi(input logic [7:0] de, input int j, input int p, input int n);
    if (!de[j]) return 0;
    return (j % 2 == 0) ? 4 * n : 4 * (p - n);
  endfunction

  task automatic pwm(input logic [3:0] de, input logic [7:0] p, input logic [7:0] n);
    int hi[8];
    int ris[8];
    int i, j;
    logic [7:0] prv;
    logic [7:0] cur;
    logic [7:0] en;
    en = {de & 4'b1001, de};
    send(cmpn_pkg::OP_PUMP, 2'h0, de, p, n);
    repeat (2 * p + 4) @(negedge clk_i);
    hi = '{0, 0, 0, 0, 0, 0, 0, 0};
    ris = '{0, 0, 0, 0, 0, 0, 0, 0};
    prv = {drv_e, drv};
    for (i = 0; i < 4 * p; i++) begin
      @(negedge clk_i);
      cur = {drv_e, drv};
      for (j = 0; j < 8; j++) begin
        hi[j] += int'(cur[j]);
        ris[j] += int'(cur[j] & ~prv[j]);
      end
      check(drv[0] & drv[1], 0);
      check(drv[2] & drv[3], 0);
      prv = cur;
    end
    for (j = 0; j < 8; j++) begin
      check(hi[j], exp_hi(en, j, p, n));
      check(ris[j], en[j] ? 4 : 0);
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (9) @(posedge clk_i);
    @(negedge clk_i);
    check({drv, so, busy, ack}, 0);
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    check({drv_e, drv}, 0);
    // serial relay, no conversion without a command
    last = 1'b0;
    for (int k = 0; k < 24; k++) begin
      @(posedge clk_i);
      si <= 1'($random(seed));
      @(negedge clk_i);
      if (k > 0) check(so, last);
      check(ctl.start, 0);
      last = si;
    end
    // voltage conversion, then a refused temperature command while busy
    v0 = $random(seed);
    v1 = $random(seed);
    val = {v1, v0};
    lag = 20;
    send(cmpn_pkg::OP_VOLT, 2'h0, 4'h0, 8'h00, 8'h00);
    check({ctl.start, ctl.temp_mode, busy}, 4'b1101);
    send(cmpn_pkg::OP_TEMP, 2'h1, 4'h0, 8'h00, 8'h00);
    check(ctl.start, 0);
    wait_idle(60);
    read(cmpn_pkg::RSEL_CELL1, v0);
    read(cmpn_pkg::RSEL_CELL2, v1);
    // every temperature source
    for (int t = 0; t < 3; t++) begin
      val = {16'($random(seed)), 16'($random(seed))};
      lag = 1 + t * 7;
      send(cmpn_pkg::OP_TEMP, 2'(t), 4'h0, 8'h00, 8'h00);
      check({ctl.start, ctl.temp_mode, ctl.temp_sel}, {2'b01, 1'b1, 2'(t)});
      wait_idle(60);
      read(3'(cmpn_pkg::RSEL_TINT + 3'(t)), val[0]);
    end
    read(cmpn_pkg::RSEL_CELL1, v0);
    // silent converters: bounded conversion, flag cleared by next command
    lag = 0;
    send(cmpn_pkg::OP_VOLT, 2'h0, 4'h0, 8'h00, 8'h00);
    wait_idle(60);
    check(tmo, 1);
    lag = 3;
    send(cmpn_pkg::OP_VOLT, 2'h0, 4'h0, 8'h00, 8'h00);
    check(tmo, 0);
    wait_idle(20);
    // balancing drives at default and random settings
    pwm(4'hf, cmpn_pkg::PERIOD_RST, cmpn_pkg::NORTH_RST);
    for (int r = 0; r < 4; r++) begin
      pe = 8'(4 + ({$random(seed)} % 37));
      no = 8'(1 + ({$random(seed)} % (pe - 1)));
      pwm(4'($random(seed)), pe, no);
    end
    pwm(4'h0, 8'd10, 8'd5);
    // standby when quiet, active on traffic
    repeat (8) @(negedge clk_i);
    check(act, 0);
    @(posedge clk_i);
    si <= ~si;
    repeat (2) @(negedge clk_i);
    check(act, 1);
    close_out();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    close_out();
  end
endmodule
